// file: sim/twc_props.sv
// twc_props: link checks between the host and device ends of the three-wire port
// assumes it sits beside the interface in the bench top; one clock domain
`timescale 1ns/1ps
module twc_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic selN,
    input wire logic hostDataOut,
    input wire logic hostDataOeN,
    input wire logic devDataOut,
    input wire logic devDataOeN,
    input wire logic dataIn
);
    logic [15:0] riseCnt;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // raw rise count per frame; it leads the device's synchronised view, so thresholds are safe
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            riseCnt <= 16'h0;
        else if ($fell(selN))
            riseCnt <= 16'h0;
        else if (!selN && $rose(sclk))
            riseCnt <= riseCnt + 16'h1;
    end

    sequence sqFirstRise;
        ##[1:8] $rose(sclk);
    endsequence

    sequence sqRelease;
        ##[0:6] devDataOeN;
    endsequence

    AST_NO_CONTENTION: assert property (!(!hostDataOeN && !devDataOeN))
        else $error("both ends drive the data line");
    AST_WIRE_VALUE: assert property (!devDataOeN |-> dataIn == devDataOut)
        else $error("data line differs from device drive");
    AST_FRAME_START: assert property ($fell(selN) |-> sqFirstRise)
        else $error("no clock rise after select fall");
    AST_HOST_DRIVES_INSTR: assert property ($fell(selN) |-> !hostDataOeN)
        else $error("host not driving instruction at frame start");
    AST_IDLE_CLOCK: assert property (selN [*4] |-> !sclk)
        else $error("serial clock active while deselected");
    AST_HALF_PERIOD: assert property (!selN && $changed(sclk) |=> $stable(sclk))
        else $error("serial clock half period too short");
    AST_WHOLE_BYTES: assert property ($rose(selN) |-> riseCnt >= 16'd16 && riseCnt[2:0] == 3'h0)
        else $error("frame is not instruction plus whole bytes");
    AST_READ_AFTER_INSTR: assert property (!devDataOeN && !selN |-> riseCnt >= 16'd16)
        else $error("device drives before instruction complete");
    AST_RELEASE: assert property ($rose(selN) |-> sqRelease)
        else $error("device holds line after select rise");
    AST_QUIET_DESELECTED: assert property (selN [*8] |-> devDataOeN)
        else $error("device drives while deselected");
    AST_HOST_DATA_EDGE: assert property (!hostDataOeN && $changed(hostDataOut) |-> !sclk)
        else $error("host data changes while clock high");
endmodule : twc_props

// file: sim/twc_tb_top.sv
// twc_tb_top: drives the host register port and checks the device end across the link
// assumes the shared data line floats high when neither end drives it
`timescale 1ns/1ps
module twc_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addrIn = 4'h0;
    logic [31:0] wrData = 32'h0;
    logic wrStb = 1'b0;
    logic rdStb = 1'b0;
    logic receiverSyncFault = 1'b0;
    logic rdLate = 1'b0;
    logic [31:0] rdData;
    logic [31:0] expQ[$];
    int err_count = 0;
    int total_checks = 0;
    logic clockDivideSetting, dutyCorrectionEnable, clockInputType, clockPinSelector, registerReferenceEnable;
    logic softwareResetBit, stateMachineSoftReset;
    logic [2:0] referenceLevelField, patternSelectField, outputSwingField;
    logic [1:0] powerModeField;
    logic [5:0] digitalOffsetField;
    logic [15:0] patternWord;
    logic [6:0] scramblerSeedLow;
    logic [7:0] serializerControlOne, portControl, b1, b2, b3;
    logic [12:0] dAdr[4] = '{13'h0003, 13'h0805, 13'h0808, 13'h0801};
    logic [7:0] dVal[4] = '{8'hff, 8'h49, 8'h03, 8'h60};
    logic [12:0] wAdr[9] = '{13'h0005, 13'h0006, 13'h0013, 13'h0014, 13'h0015, 13'h0016, 13'h0802, 13'h0808,
        13'h0809};
    logic [7:0] wMsk[9] = '{8'h83, 8'h1b, 8'h3f, 8'h07, 8'hff, 8'hff, 8'h88, 8'h07, 8'h7f};

    twc_if link();
    // contention shows as unknown; the line idles high
    assign link.dataIn = (!link.hostDataOeN && !link.devDataOeN) ? 1'bx :
        (!link.hostDataOeN ? link.hostDataOut : (!link.devDataOeN ? link.devDataOut : 1'b1));

    always #2 clk = ~clk;

    twc_host i_twc_host (.clk(clk), .rst_n(rst_n), .link(link.host), .addrIn(addrIn), .wrData(wrData),
        .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData));
    twc_device i_twc_device (.clk(clk), .rst_n(rst_n), .link(link.device), .receiverSyncFault(receiverSyncFault),
        .clockDivideSetting(clockDivideSetting), .dutyCorrectionEnable(dutyCorrectionEnable),
        .clockInputType(clockInputType), .clockPinSelector(clockPinSelector),
        .registerReferenceEnable(registerReferenceEnable), .referenceLevelField(referenceLevelField),
        .powerModeField(powerModeField), .softwareResetBit(softwareResetBit),
        .stateMachineSoftReset(stateMachineSoftReset), .digitalOffsetField(digitalOffsetField),
        .patternSelectField(patternSelectField), .patternWord(patternWord), .outputSwingField(outputSwingField),
        .scramblerSeedLow(scramblerSeedLow), .serializerControlOne(serializerControlOne), .portControl(portControl));
    twc_props i_twc_props (.clk(clk), .rst_n(rst_n), .sclk(link.sclk), .selN(link.selN),
        .hostDataOut(link.hostDataOut), .hostDataOeN(link.hostDataOeN), .devDataOut(link.devDataOut),
        .devDataOeN(link.devDataOeN), .dataIn(link.dataIn));

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL %0t read data %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic cmpOut(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL %0t config output %h expected %h", $time, got, exp);
        end
    endtask : cmpOut

    // read data appear one cycle after the strobe and only then
    always @(posedge clk)
    begin
        if (rdLate)
            cmp(rdData, expQ.pop_front());
        rdLate <= rdStb;
    end

    task automatic regWrite(input logic [3:0] a, input logic [31:0] v);
        addrIn <= a;
        wrData <= v;
        wrStb <= 1'b1;
        rdStb <= 1'b0;
        @(posedge clk);
    endtask : regWrite

    task automatic regRead(input logic [3:0] a, input logic [31:0] exp);
        expQ.push_back(exp);
        addrIn <= a;
        wrStb <= 1'b0;
        rdStb <= 1'b1;
        @(posedge clk);
    endtask : regRead

    task automatic idle();
        wrStb <= 1'b0;
        rdStb <= 1'b0;
        @(posedge clk);
    endtask : idle

    // one frame; the settle wait covers the device's two-flop synchroniser
    task automatic frame(input logic rd, input logic [1:0] cnt, input logic [12:0] a, input logic [7:0] b);
        int n;
        regWrite(4'h1, {24'h0, b});
        regWrite(4'h0, {15'h0, 1'b1, rd, cnt, a});
        idle();
        for (n = 0; n < 10 && link.selN !== 1'b0; n++)
            @(posedge clk);
        if (link.selN !== 1'b0)
        begin
            err_count++;
            $display("FAIL %0t frame did not start", $time);
        end
        for (n = 0; n < 3000 && link.selN !== 1'b1; n++)
            @(posedge clk);
        if (link.selN !== 1'b1)
        begin
            err_count++;
            $display("FAIL %0t frame did not end", $time);
        end
        repeat (6) @(posedge clk);
        regRead(4'h2, 32'h0);
    endtask : frame

    task automatic endTest(input string s);
        $display("test %s done", s);
    endtask : endTest

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    initial
    begin
        #200000;
        err_count++;
        $display("FAIL %0t watchdog expired", $time);
        complete_run();
    end

    initial
    begin
        void'($urandom(32'h942a));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        cmpOut({8'h0, portControl}, 16'h00ff);
        cmpOut({8'h0, serializerControlOne}, 16'h0049);
        cmpOut({13'h0, outputSwingField}, 16'h0003);
        cmpOut(patternWord, 16'h0000);
        for (int i = 0; i < 4; i++)
        begin
            frame(1'b1, twc_pkg::CNT_ONE, dAdr[i], 8'h00);
            regRead(4'h3, {24'h0, dVal[i]});
        end
        endTest("defaults");
        // bit 7 kept clear so the shared soft reset never fires mid-test
        for (int i = 0; i < 9; i++)
        begin
            b1 = 8'($urandom()) & 8'h7f;
            frame(1'b0, twc_pkg::CNT_ONE, wAdr[i], b1);
            frame(1'b1, twc_pkg::CNT_ONE, wAdr[i], 8'h00);
            regRead(4'h3, {24'h0, b1 & wMsk[i]});
        end
        cmpOut({9'h0, scramblerSeedLow}, {8'h0, b1 & 8'h7f});
        frame(1'b0, twc_pkg::CNT_ONE, twc_pkg::ADR_SER_RESET, 8'h88);
        frame(1'b0, twc_pkg::CNT_ONE, twc_pkg::ADR_RESET_MODE, 8'h02);
        cmpOut({12'h0, softwareResetBit, stateMachineSoftReset, powerModeField}, 16'h0006);
        endTest("registers");
        frame(1'b0, twc_pkg::CNT_ONE, twc_pkg::ADR_CLOCK_CFG, 8'h1b);
        cmpOut({11'h0, clockPinSelector, clockInputType, 1'b0, clockDivideSetting, dutyCorrectionEnable},
            16'h001b);
        frame(1'b0, twc_pkg::CNT_ONE, twc_pkg::ADR_CLOCK_CFG, 8'h08);
        cmpOut({11'h0, clockPinSelector, clockInputType, 1'b0, clockDivideSetting, dutyCorrectionEnable},
            16'h0008);
        frame(1'b0, twc_pkg::CNT_ONE, twc_pkg::ADR_REF_LEVEL, 8'h0e);
        frame(1'b0, twc_pkg::CNT_ONE, twc_pkg::ADR_REF_LEVEL, 8'h0f);
        cmpOut({12'h0, registerReferenceEnable, referenceLevelField}, 16'h000e);
        endTest("clockref");
        b1 = 8'($urandom());
        b2 = 8'($urandom());
        b3 = 8'($urandom());
        frame(1'b0, 2'h1, twc_pkg::ADR_PAT_HIGH, b1);
        cmpOut(patternWord, {b1, b1});
        frame(1'b0, twc_pkg::CNT_MANY, twc_pkg::ADR_DIG_OFFSET, b2);
        cmpOut({digitalOffsetField, patternSelectField, patternWord[6:0]}, {b2[5:0], b2[2:0], b2[6:0]});
        frame(1'b0, 2'h2, twc_pkg::ADR_PAT_SEL, b3);
        cmpOut({digitalOffsetField, patternSelectField, patternWord[15:9]}, {b2[5:0], b3[2:0], b3[7:1]});
        frame(1'b1, 2'h1, twc_pkg::ADR_DIG_OFFSET, 8'h00);
        regRead(4'h3, {29'h0, b3[2:0]});
        endTest("autoinc");
        frame(1'b0, twc_pkg::CNT_ONE, twc_pkg::ADR_SER_STATUS, 8'h00);
        receiverSyncFault <= 1'b1;
        idle();
        receiverSyncFault <= 1'b0;
        frame(1'b1, twc_pkg::CNT_ONE, twc_pkg::ADR_SER_STATUS, 8'h00);
        regRead(4'h3, 32'he0);
        frame(1'b1, twc_pkg::CNT_ONE, twc_pkg::ADR_SER_STATUS, 8'h00);
        regRead(4'h3, 32'h60);
        regRead(4'h5, 32'h0);
        regRead(4'h3, 32'h60);
        idle();
        endTest("status");
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        cmpOut(patternWord, 16'h0000);
        cmpOut({8'h0, portControl}, 16'h00ff);
        frame(1'b1, twc_pkg::CNT_ONE, twc_pkg::ADR_PAT_HIGH, 8'h00);
        regRead(4'h3, 32'h0);
        idle();
        repeat (2) @(posedge clk);
        endTest("reset");
        complete_run();
    end
endmodule : twc_tb_top

// file: verilog/twc_device.sv
// twc_device: register end of the three-wire configuration port
// assumes the link pins are asynchronous and are synchronised to clk here
`timescale 1ns/1ps
// Contract
// - clock, select and one shared data line
// - serial activity only while select low
// - select fall then sclk rise starts
// - two instruction bytes precede data
// - instruction bit 7: 0 write, 1 read
// - bits 6:5 give the byte count
// - thirteen-bit address from both instruction bytes
// - address counter increments per later byte
// - data phase is whole bytes
// - every byte shifted msb first
// - select rise ends transfer, releases line
// - divide setting selects clock divide by two
// - duty correction enable switches stabiliser
// - register reference field sets full scale
// - pin selector picks single-ended clock pin
module twc_device (
    input wire logic clk,
    input wire logic rst_n,
    twc_if.device link,
    input wire logic receiverSyncFault,
    output logic clockDivideSetting,
    output logic dutyCorrectionEnable,
    output logic clockInputType,
    output logic clockPinSelector,
    output logic registerReferenceEnable,
    output logic [2:0] referenceLevelField,
    output logic [1:0] powerModeField,
    output logic softwareResetBit,
    output logic stateMachineSoftReset,
    output logic [5:0] digitalOffsetField,
    output logic [2:0] patternSelectField,
    output logic [15:0] patternWord,
    output logic [2:0] outputSwingField,
    output logic [6:0] scramblerSeedLow,
    output logic [7:0] serializerControlOne,
    output logic [7:0] portControl
);
    typedef enum logic [1:0] {
        TWC_IDLE = 2'b00,
        TWC_INSTR = 2'b01,
        TWC_DATA = 2'b10
    } twc_dstate_t;

    logic [1:0] sclkSync;
    logic [1:0] selSync;
    logic [1:0] dinSync;
    logic sclkLast;
    twc_dstate_t state;
    logic [2:0] bitCnt;
    logic byteIdx;
    logic [7:0] shiftIn;
    logic [7:0] shiftOut;
    logic isRead;
    logic [12:0] addr;
    logic [4:0] addrHigh;
    logic [7:0] rdReg;
    logic oeN;
    logic [7:0] syncFaultSeen;

    wire sclkRise = sclkSync[1] & ~sclkLast;
    wire sclkFall = ~sclkSync[1] & sclkLast;
    wire selActive = ~selSync[1];
    wire byteDone = sclkRise & (bitCnt == 3'h7);
    wire [7:0] byteIn = {shiftIn[6:0], dinSync[1]}; // msb first
    wire writeStb = (state == TWC_DATA) & byteDone & ~isRead;
    wire [12:0] nextAddr = addr + 13'h0001;
    wire [7:0] statusByte = {syncFaultSeen[7], 7'h00} | twc_pkg::RST_SER_STATUS;

    // register readback mux
    always_comb
    begin
        case (addr)
            twc_pkg::ADR_PORT_CTRL: rdReg = portControl;
            twc_pkg::ADR_RESET_MODE: rdReg = {softwareResetBit, 5'h00, powerModeField};
            twc_pkg::ADR_CLOCK_CFG: rdReg = {3'h0, clockPinSelector, clockInputType, 1'b0,
                clockDivideSetting, dutyCorrectionEnable};
            twc_pkg::ADR_REF_LEVEL: rdReg = {4'h0, registerReferenceEnable, referenceLevelField};
            twc_pkg::ADR_DIG_OFFSET: rdReg = {2'h0, digitalOffsetField};
            twc_pkg::ADR_PAT_SEL: rdReg = {5'h00, patternSelectField};
            twc_pkg::ADR_PAT_HIGH: rdReg = patternWord[15:8];
            twc_pkg::ADR_PAT_LOW: rdReg = patternWord[7:0];
            twc_pkg::ADR_SER_STATUS: rdReg = statusByte;
            twc_pkg::ADR_SER_RESET: rdReg = {softwareResetBit, 3'h0, stateMachineSoftReset, 3'h0};
            twc_pkg::ADR_SER_CTRL1: rdReg = serializerControlOne;
            twc_pkg::ADR_SWING: rdReg = {5'h00, outputSwingField};
            twc_pkg::ADR_SCRAMBLER: rdReg = {1'b0, scramblerSeedLow};
            default: rdReg = 8'h00;
        endcase
    end

    // link pins are asynchronous to clk
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sclkSync <= 2'h0;
            selSync <= 2'h3;
            dinSync <= 2'h0;
            sclkLast <= 1'b0;
        end
        else
        begin
            sclkSync <= {sclkSync[0], link.sclk};
            selSync <= {selSync[0], link.selN};
            dinSync <= {dinSync[0], link.dataIn};
            sclkLast <= sclkSync[1];
        end
    end

    // frame sequencer
    always_ff @(posedge clk)
    begin
        if (!rst_n || !selActive)
        begin
            state <= TWC_IDLE;
            bitCnt <= 3'h0;
            byteIdx <= 1'b0;
            shiftIn <= 8'h00;
            isRead <= 1'b0;
            addr <= 13'h0000;
            addrHigh <= 5'h00;
        end
        else
        begin
            case (state)
                TWC_IDLE:
                begin
                    // first rising sclk after select fall opens the frame
                    if (sclkRise)
                    begin
                        state <= TWC_INSTR;
                        shiftIn <= byteIn;
                        bitCnt <= 3'h1;
                    end
                end
                TWC_INSTR:
                begin
                    if (sclkRise)
                    begin
                        shiftIn <= byteIn;
                        bitCnt <= bitCnt + 3'h1;
                    end
                    if (byteDone && !byteIdx)
                    begin
                        isRead <= byteIn[twc_pkg::DIR_BIT];
                        addrHigh <= byteIn[4:0];
                        byteIdx <= 1'b1;
                    end
                    else if (byteDone)
                    begin
                        addr <= {addrHigh, byteIn};
                        state <= TWC_DATA;
                    end
                end
                TWC_DATA:
                begin
                    // the count field is informational; select rise alone ends a frame
                    if (sclkRise)
                    begin
                        shiftIn <= byteIn;
                        bitCnt <= bitCnt + 3'h1; // wraps per byte
                    end
                    if (byteDone)
                    begin
                        addr <= nextAddr;
                    end
                end
                default: state <= TWC_IDLE;
            endcase
        end
    end

    // read path: load on the falling edge before each data byte, shift on falls
    always_ff @(posedge clk)
    begin
        if (!rst_n || !selActive)
        begin
            shiftOut <= 8'h00;
            oeN <= 1'b1;
        end
        else if (sclkFall && state == TWC_DATA && isRead)
        begin
            oeN <= 1'b0;
            shiftOut <= (bitCnt == 3'h0) ? rdReg : {shiftOut[6:0], 1'b0};
        end
    end

    assign link.devDataOut = shiftOut[7];
    assign link.devDataOeN = oeN;

    // sticky sync fault, cleared by reading the status register
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            syncFaultSeen <= 8'h00;
        else if (receiverSyncFault)
            syncFaultSeen <= 8'h80; // set beats clear
        else if (state == TWC_DATA && isRead && byteDone && addr == twc_pkg::ADR_SER_STATUS)
            syncFaultSeen <= 8'h00;
    end

    // configuration registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            portControl <= twc_pkg::RST_PORT_CTRL;
            {softwareResetBit, powerModeField} <= 3'h0;
            {clockPinSelector, clockInputType, clockDivideSetting, dutyCorrectionEnable} <= 4'h0;
            {registerReferenceEnable, referenceLevelField} <= 4'h0;
            digitalOffsetField <= 6'h00;
            patternSelectField <= 3'h0;
            patternWord <= 16'h0000;
            stateMachineSoftReset <= 1'b0;
            serializerControlOne <= twc_pkg::RST_SER_CTRL1;
            outputSwingField <= twc_pkg::RST_SWING[2:0];
            scramblerSeedLow <= 7'h00;
        end
        else if (writeStb)
        begin
            case (addr)
                twc_pkg::ADR_PORT_CTRL: portControl <= byteIn;
                twc_pkg::ADR_RESET_MODE: {softwareResetBit, powerModeField} <= {byteIn[7], byteIn[1:0]};
                twc_pkg::ADR_CLOCK_CFG:
                begin
                    clockPinSelector <= byteIn[twc_pkg::CLK_PIN_BIT];
                    clockInputType <= byteIn[twc_pkg::CLK_TYPE_BIT];
                    clockDivideSetting <= byteIn[twc_pkg::CLK_DIV2_BIT];
                    dutyCorrectionEnable <= byteIn[twc_pkg::CLK_DCS_BIT];
                end
                twc_pkg::ADR_REF_LEVEL:
                begin
                    registerReferenceEnable <= byteIn[twc_pkg::REF_EN_BIT];
                    // unused code is refused, level keeps its last value
                    if (byteIn[2:0] != twc_pkg::REF_UNUSED)
                        referenceLevelField <= byteIn[2:0];
                end
                twc_pkg::ADR_DIG_OFFSET: digitalOffsetField <= byteIn[5:0];
                twc_pkg::ADR_PAT_SEL: patternSelectField <= byteIn[2:0];
                twc_pkg::ADR_PAT_HIGH: patternWord[15:8] <= byteIn;
                twc_pkg::ADR_PAT_LOW: patternWord[7:0] <= byteIn;
                twc_pkg::ADR_SER_RESET: {softwareResetBit, stateMachineSoftReset} <= {byteIn[7], byteIn[3]};
                twc_pkg::ADR_SER_CTRL1: serializerControlOne <= byteIn;
                twc_pkg::ADR_SWING: outputSwingField <= byteIn[2:0];
                twc_pkg::ADR_SCRAMBLER: scramblerSeedLow <= byteIn[6:0];
                default: ;
            endcase
        end
    end
endmodule : twc_device

// file: verilog/twc_host.sv
// twc_host: master end that runs one frame per software command
// assumes the device answers read data on falling sclk edges
`timescale 1ns/1ps
module twc_host (
    input wire logic clk,
    input wire logic rst_n,
    twc_if.host link,
    input wire logic [3:0] addrIn,
    input wire logic [31:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [31:0] rdData
);
    // regs: 0 command {go,dir,count[1:0],addr[12:0]}, 1 write byte, 2 status {busy}, 3 read byte
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_WDATA = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam logic [3:0] REG_RDATA = 4'h3;
    typedef enum logic [1:0] {
        TWC_H_IDLE = 2'b00,
        TWC_H_SHIFT = 2'b01,
        TWC_H_END = 2'b10
    } twc_hstate_t;

    twc_hstate_t state;
    logic [1:0] dinSync;
    logic [15:0] cmd;
    logic [7:0] wByte;
    logic [7:0] rByte;
    logic [7:0] shifter;
    logic [5:0] bitsLeft;
    logic [2:0] bytesLeft;
    logic [7:0] halfCnt;
    logic isRd;

    wire go = wrStb & (addrIn == REG_CMD) & wrData[16] & (state == TWC_H_IDLE);
    wire halfDone = (halfCnt == 8'(twc_pkg::SCLK_HALF - 1));
    wire [2:0] nBytes = {1'b0, wrData[14:13]} + 3'h1;
    wire inData = (bitsLeft <= 6'(8 * bytesLeft)) & (bitsLeft != 6'h00);
    wire [31:0] readMux = (addrIn == REG_STATUS) ? {31'h0, state != TWC_H_IDLE} :
                          (addrIn == REG_RDATA) ? {24'h0, rByte} : 32'h0;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            dinSync <= 2'h0;
            rdData <= 32'h0;
            wByte <= 8'h00;
        end
        else
        begin
            dinSync <= {dinSync[0], link.dataIn};
            rdData <= rdStb ? readMux : 32'h0;
            if (wrStb && addrIn == REG_WDATA)
                wByte <= wrData[7:0];
        end
    end

    // frame engine; count 11 is sent as four bytes
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state <= TWC_H_IDLE;
            link.sclk <= 1'b0;
            link.selN <= 1'b1;
            link.hostDataOut <= 1'b0;
            link.hostDataOeN <= 1'b1;
            cmd <= 16'h0000;
            shifter <= 8'h00;
            rByte <= 8'h00;
            bitsLeft <= 6'h00;
            bytesLeft <= 3'h0;
            halfCnt <= 8'h00;
            isRd <= 1'b0;
        end
        else
        begin
            case (state)
                TWC_H_IDLE:
                begin
                    if (go)
                    begin
                        cmd <= {wrData[15], wrData[14:13], wrData[12:0]};
                        isRd <= wrData[15];
                        bytesLeft <= nBytes;
                        bitsLeft <= 6'd16 + 6'(8 * nBytes);
                        link.selN <= 1'b0;
                        link.hostDataOeN <= 1'b0;
                        link.hostDataOut <= wrData[15];
                        halfCnt <= 8'h00;
                        state <= TWC_H_SHIFT;
                    end
                end
                TWC_H_SHIFT:
                begin
                    halfCnt <= halfDone ? 8'h00 : halfCnt + 8'h01;
                    if (halfDone && !link.sclk)
                    begin
                        link.sclk <= 1'b1;
                        if (inData && isRd)
                            shifter <= {shifter[6:0], dinSync[1]};
                        bitsLeft <= bitsLeft - 6'h01;
                    end
                    else if (halfDone)
                    begin
                        link.sclk <= 1'b0;
                        cmd <= {cmd[14:0], 1'b0};
                        if (bitsLeft == 6'h00)
                        begin
                            rByte <= shifter;
                            state <= TWC_H_END;
                        end
                        else if (bitsLeft > 6'(8 * bytesLeft))
                            link.hostDataOut <= cmd[14];
                        else if (isRd)
                            link.hostDataOeN <= 1'b1;
                        else
                            link.hostDataOut <= wByte[3'(bitsLeft - 6'h01)];
                    end
                end
                TWC_H_END:
                begin
                    link.selN <= 1'b1;
                    link.hostDataOeN <= 1'b1;
                    state <= TWC_H_IDLE;
                end
                default: state <= TWC_H_IDLE;
            endcase
        end
    end
endmodule : twc_host

// file: verilog/twc_if.sv
// twc_if: three-wire link between host and device ends
// assumes the bench resolves the shared data wire from the two enables
`timescale 1ns/1ps
interface twc_if;
    logic sclk;
    logic selN;
    logic hostDataOut;
    logic hostDataOeN;
    logic devDataOut;
    logic devDataOeN;
    logic dataIn;
    modport host (output sclk, output selN, output hostDataOut, output hostDataOeN, input dataIn);
    modport device (input sclk, input selN, output devDataOut, output devDataOeN, input dataIn);
endinterface : twc_if

// file: verilog/twc_pkg.sv
// twc_pkg: shared constants for the three-wire configuration port
// assumes both ends and the bench use package::name references
package twc_pkg;
    localparam int ADDR_W = 13;
    localparam int BYTE_W = 8;
    localparam int DIR_BIT = 7;
    localparam int CNT_HI_BIT = 6;
    localparam int CNT_LO_BIT = 5;
    localparam logic [1:0] CNT_ONE = 2'h0;
    localparam logic [1:0] CNT_MANY = 2'h3;
    localparam logic [12:0] ADR_PORT_CTRL = 13'h0003;
    localparam logic [12:0] ADR_RESET_MODE = 13'h0005;
    localparam logic [12:0] ADR_CLOCK_CFG = 13'h0006;
    localparam logic [12:0] ADR_REF_LEVEL = 13'h0008;
    localparam logic [12:0] ADR_DIG_OFFSET = 13'h0013;
    localparam logic [12:0] ADR_PAT_SEL = 13'h0014;
    localparam logic [12:0] ADR_PAT_HIGH = 13'h0015;
    localparam logic [12:0] ADR_PAT_LOW = 13'h0016;
    localparam logic [12:0] ADR_SER_STATUS = 13'h0801;
    localparam logic [12:0] ADR_SER_RESET = 13'h0802;
    localparam logic [12:0] ADR_SER_CTRL1 = 13'h0805;
    localparam logic [12:0] ADR_SWING = 13'h0808;
    localparam logic [12:0] ADR_SCRAMBLER = 13'h0809;
    localparam logic [7:0] RST_PORT_CTRL = 8'hff;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_SER_STATUS = 8'h60;
    localparam logic [7:0] RST_SER_CTRL1 = 8'h49;
    localparam logic [7:0] RST_SWING = 8'h03;
    // writable bits per register; unused bits read as zero
    localparam logic [7:0] MSK_RESET_MODE = 8'h83;
    localparam logic [7:0] MSK_CLOCK_CFG = 8'h1b;
    localparam logic [7:0] MSK_REF_LEVEL = 8'h0f;
    localparam logic [7:0] MSK_DIG_OFFSET = 8'h3f;
    localparam logic [7:0] MSK_PAT_SEL = 8'h07;
    localparam logic [7:0] MSK_SER_RESET = 8'h88;
    localparam logic [7:0] MSK_SWING = 8'h07;
    localparam logic [7:0] MSK_SCRAMBLER = 8'h7f;
    localparam int CLK_DCS_BIT = 0;
    localparam int CLK_DIV2_BIT = 1;
    localparam int CLK_TYPE_BIT = 3;
    localparam int CLK_PIN_BIT = 4;
    localparam int REF_EN_BIT = 3;
    localparam logic [2:0] REF_UNUSED = 3'h7;
    localparam int SYNC_FAULT_BIT = 7;
    // host drives serial clock at clk / (2 * SCLK_HALF)
    // read data return five clocks after a fall (three to load, two to resync), so a half period needs six
    localparam int SCLK_HALF = 6;
endpackage : twc_pkg
